// file: inc/aw_fifo_map.svh
// Purpose: field widths, reset values and fixed positions of the
//          write address queue
// Assumes: included by bare name; guarded against double inclusion
// Notes:   definitions only
`ifndef AW_FIFO_MAP_SVH
`define AW_FIFO_MAP_SVH

// ------------------------------------------------------------
// control field widths of one address beat
// ------------------------------------------------------------
`define AW_LEN_W 8
`define AW_SIZE_W 3
`define AW_BURST_W 2
`define AW_LOCK_W 3
`define AW_CACHE_W 5
`define AW_PROT_W 4
`define AW_QOS_W 4
`define AW_REGION_W 4
`define AW_CTRL_W 33

// ------------------------------------------------------------
// default geometry and reset values
// ------------------------------------------------------------
`define AW_DEPTH_DEF 16
`define AW_ID_W_DEF 4
`define AW_ADDR_W_DEF 32
`define AW_USER_W_DEF 1
`define AW_FLAG_RST 1'b0
`define AW_TFULL_RST 1'b0
`define AW_TEMPTY_RST 1'b1

// ------------------------------------------------------------
// codeword bits flipped by error injection
// ------------------------------------------------------------
`define AW_INJ_BIT_A 3
`define AW_INJ_BIT_B 5

`endif

// file: inc/aw_fifo_pkg.sv
// Purpose: shared types of the write address queue
// Assumes: aw_fifo_map.svh supplies the widths
// Notes:   control fields travel as one packed struct
`include "aw_fifo_map.svh"

package aw_fifo_pkg;

  // fixed-width control fields, packed in this order into the word
  typedef struct packed {
    logic [`AW_LEN_W-1:0] len;
    logic [`AW_SIZE_W-1:0] size;
    logic [`AW_BURST_W-1:0] burst;
    logic [`AW_LOCK_W-1:0] lock;
    logic [`AW_CACHE_W-1:0] cache;
    logic [`AW_PROT_W-1:0] prot;
    logic [`AW_QOS_W-1:0] qos;
    logic [`AW_REGION_W-1:0] region;
  } aw_ctrl_t;

  // output holding stage
  typedef enum logic {OUT_EMPTY, OUT_HOLD} out_state_t;

endpackage

// file: inc/aw_store_if.sv
// Purpose: carrier between queue control and its storage array
// Assumes: one clock; storage read is combinational
// Notes:   ctrl drives writes and read address, mem answers
`timescale 1ns/1ps
`default_nettype none

interface aw_store_if #(
  parameter int AW = 4,
  parameter int W = 8
) ();
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0] wr_word;
  logic inj_single;
  logic inj_double;
  logic [AW-1:0] rd_addr;
  logic [W-1:0] rd_word;
  logic rd_single;
  logic rd_double;

  modport ctrl (
    output wr_en, wr_addr, wr_word, inj_single, inj_double, rd_addr,
    input rd_word, rd_single, rd_double
  );
  modport mem (
    input wr_en, wr_addr, wr_word, inj_single, inj_double, rd_addr,
    output rd_word, rd_single, rd_double
  );
endinterface

`default_nettype wire

// file: src/aw_fifo_store.sv
// Purpose: storage array of the address queue with optional SECDED
// Assumes: write on clk, read combinational at rd_addr
// Notes:   extended Hamming code, overall parity in codeword bit 0
`timescale 1ns/1ps
`default_nettype none

module aw_fifo_store #(
  parameter int DEPTH = 16,
  parameter int W = 8,
  parameter bit ECC_ENABLE = 1'b1
) (
  input wire logic clk,
  aw_store_if.mem st
);

  // ------------------------------------------------------------
  // code geometry
  // ------------------------------------------------------------
  function automatic int parity_bits(int w);
    int p;
    p = 1;
    while ((1 << p) < w + p + 1)
    begin
      p++;
    end
    return p;
  endfunction

  localparam int P = parity_bits(W);
  localparam int CW = W + P + 1;

  // place data in non-power-of-two positions, then fill parity
  function automatic logic [CW-1:0] encode(logic [W-1:0] d);
    logic [CW-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 1; i < CW; i++)
    begin
      if ((i & (i - 1)) != 0)
      begin
        c[i] = d[k];
        k++;
      end
    end
    for (int j = 0; j < P; j++)
    begin
      for (int i = 1; i < CW; i++)
      begin
        if (((i >> j) & 1) == 1 && i != (1 << j))
          c[1 << j] ^= c[i];
      end
    end
    c[0] = ^c;
    return c;
  endfunction

  // returns {double, single, corrected data}
  function automatic logic [W+1:0] decode(logic [CW-1:0] c);
    logic [CW-1:0] f;
    logic [P-1:0] s;
    logic [W-1:0] d;
    logic ov;
    logic dbl;
    int k;
    f = c;
    s = '0;
    d = '0;
    k = 0;
    for (int j = 0; j < P; j++)
    begin
      for (int i = 1; i < CW; i++)
      begin
        if (((i >> j) & 1) == 1)
          s[j] ^= c[i];
      end
    end
    ov = ^c;
    dbl = (s != '0) && !ov;
    // a syndrome past the codeword cannot be a single flip
    if (ov && int'(s) < CW)
      f[s] = ~f[s];
    else if (ov)
      dbl = 1'b1;
    for (int i = 1; i < CW; i++)
    begin
      if ((i & (i - 1)) != 0)
      begin
        d[k] = f[i];
        k++;
      end
    end
    return {dbl, ov && !dbl, d};
  endfunction

  // ------------------------------------------------------------
  // array with or without code bits
  // ------------------------------------------------------------
  generate
    if (ECC_ENABLE)
    begin : g_ecc
      logic [CW-1:0] mem [DEPTH];
      logic [CW-1:0] cw;
      logic [W+1:0] dec;

      // double injection wins over single when both are raised
      always_comb
      begin
        cw = encode(st.wr_word);
        if (st.inj_double)
        begin
          cw[`AW_INJ_BIT_A] = ~cw[`AW_INJ_BIT_A];
          cw[`AW_INJ_BIT_B] = ~cw[`AW_INJ_BIT_B];
        end
        else if (st.inj_single)
          cw[`AW_INJ_BIT_A] = ~cw[`AW_INJ_BIT_A];
      end

      always_ff @(posedge clk)
      begin
        if (st.wr_en)
          mem[st.wr_addr] <= cw;
      end

      assign dec = decode(mem[st.rd_addr]);
      assign st.rd_word = dec[W-1:0];
      assign st.rd_single = dec[W];
      assign st.rd_double = dec[W+1];
    end
    else
    begin : g_raw
      logic [W-1:0] mem [DEPTH];

      // injection has no meaning without code bits
      always_ff @(posedge clk)
      begin
        if (st.wr_en)
          mem[st.wr_addr] <= st.wr_word;
      end

      assign st.rd_word = mem[st.rd_addr];
      assign st.rd_single = 1'b0;
      assign st.rd_double = 1'b0;
    end
  endgenerate

endmodule

`default_nettype wire

// file: src/aw_fifo_top.sv
// Purpose: queue in an AXI4 write address channel, slave port in,
//          master port out, with count, threshold and error sideband
// Assumes: both ports and all sideband on clk; inputs come from
//          logic on clk, so none is synchronised
// Notes:   capacity is DEPTH words including the output holding stage
`timescale 1ns/1ps
`default_nettype none
`include "aw_fifo_map.svh"

// Notes on behaviour
// - awready high exactly when a beat fits
// - awvalid shows held entry, stable until taken
// - id, addr, len, size, burst, qos, region, user stored
// - lock, cache, protection fields pass unaltered
// - refused write raises overflow next cycle
// - refused read raises underflow next cycle
// - write count never underreports, one edge lag
// - read count never overreports, one edge lag
// - stored count is log2(depth)+1 bits
// - threshold full while count at/above threshold
// - threshold empty while count at/below threshold
// - single inject flips one written bit
// - double inject flips two written bits
// - corrected word flagged single error alongside
// - uncorrectable word flagged double error
// - both ports sampled on rising clock edge
// - active-low reset empties the queue
// - beat moves only when valid and ready
module aw_fifo_top
  import aw_fifo_pkg::*;
#(
  parameter int DEPTH = `AW_DEPTH_DEF,
  parameter int ID_W = `AW_ID_W_DEF,
  parameter int ADDR_W = `AW_ADDR_W_DEF,
  parameter int USER_W = `AW_USER_W_DEF,
  parameter bit ECC_ENABLE = 1'b1,
  localparam int AW = $clog2(DEPTH),
  localparam int CNT_W = AW + 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ID_W-1:0] s_axi_awid,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [`AW_LEN_W-1:0] s_axi_awlen,
  input wire logic [`AW_SIZE_W-1:0] s_axi_awsize,
  input wire logic [`AW_BURST_W-1:0] s_axi_awburst,
  input wire logic [`AW_LOCK_W-1:0] s_axi_awlock,
  input wire logic [`AW_CACHE_W-1:0] s_axi_awcache,
  input wire logic [`AW_PROT_W-1:0] s_axi_awprot,
  input wire logic [`AW_QOS_W-1:0] s_axi_awqos,
  input wire logic [`AW_REGION_W-1:0] s_axi_awregion,
  input wire logic [USER_W-1:0] s_axi_awuser,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  output logic [ID_W-1:0] m_axi_awid,
  output logic [ADDR_W-1:0] m_axi_awaddr,
  output logic [`AW_LEN_W-1:0] m_axi_awlen,
  output logic [`AW_SIZE_W-1:0] m_axi_awsize,
  output logic [`AW_BURST_W-1:0] m_axi_awburst,
  output logic [`AW_LOCK_W-1:0] m_axi_awlock,
  output logic [`AW_CACHE_W-1:0] m_axi_awcache,
  output logic [`AW_PROT_W-1:0] m_axi_awprot,
  output logic [`AW_QOS_W-1:0] m_axi_awqos,
  output logic [`AW_REGION_W-1:0] m_axi_awregion,
  output logic [USER_W-1:0] m_axi_awuser,
  output logic m_axi_awvalid,
  input wire logic m_axi_awready,
  input wire logic [AW-1:0] aw_full_threshold,
  input wire logic [AW-1:0] aw_empty_threshold,
  input wire logic aw_inject_single_error,
  input wire logic aw_inject_double_error,
  output logic aw_single_error_flag,
  output logic aw_double_error_flag,
  output logic aw_overflow_flag,
  output logic aw_underflow_flag,
  output logic [CNT_W-1:0] aw_write_side_count,
  output logic [CNT_W-1:0] aw_read_side_count,
  output logic [CNT_W-1:0] aw_stored_count,
  output logic aw_threshold_full_flag,
  output logic aw_threshold_empty_flag
);

  // ------------------------------------------------------------
  // geometry checks
  // ------------------------------------------------------------
  localparam int W = ID_W + ADDR_W + USER_W + `AW_CTRL_W;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("depth must be a power of two, at least two");
    end
    if (ID_W < 1 || ADDR_W < 1 || USER_W < 1)
    begin : g_bad_width
      $error("id, address and user widths must be at least one");
    end
  endgenerate

  // ------------------------------------------------------------
  // word packing
  // ------------------------------------------------------------
  // layout, high to low: id, addr, user, control fields
  function automatic logic [W-1:0] pack_beat(
    logic [ID_W-1:0] id,
    logic [ADDR_W-1:0] addr,
    logic [USER_W-1:0] user,
    aw_ctrl_t ctrl
  );
    return {id, addr, user, ctrl};
  endfunction

  aw_ctrl_t in_ctrl;
  aw_ctrl_t out_ctrl;

  // every control field lands in the word untouched
  always_comb
  begin
    in_ctrl.len = s_axi_awlen;
    in_ctrl.size = s_axi_awsize;
    in_ctrl.burst = s_axi_awburst;
    in_ctrl.lock = s_axi_awlock;
    in_ctrl.cache = s_axi_awcache;
    in_ctrl.prot = s_axi_awprot;
    in_ctrl.qos = s_axi_awqos;
    in_ctrl.region = s_axi_awregion;
  end

  // ------------------------------------------------------------
  // handshake and occupancy
  // ------------------------------------------------------------
  out_state_t state_q;
  out_state_t state_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] mem_cnt_q;
  logic [CNT_W-1:0] mem_cnt_d;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [W-1:0] out_word_q;
  logic out_single_q;
  logic out_double_q;
  logic push;
  logic pop;
  logic load;

  aw_store_if #(.AW(AW), .W(W)) st ();

  // ready only while a slot is free; the holding stage counts too
  assign s_axi_awready = (count_q != FULL_CNT);
  assign m_axi_awvalid = (state_q == OUT_HOLD);
  // transfers happen only on valid and ready together
  assign push = s_axi_awvalid && s_axi_awready;
  assign pop = m_axi_awvalid && m_axi_awready;
  // refill the holding stage when empty or being drained
  assign load = (mem_cnt_q != '0) && (state_q == OUT_EMPTY || pop);

  // occupancy arithmetic, cut back to counter width on purpose
  always_comb
  begin
    count_d = count_q;
    mem_cnt_d = mem_cnt_q;
    if (push && !pop)
      count_d = CNT_W'(count_q + 1'b1);
    else if (pop && !push)
      count_d = CNT_W'(count_q - 1'b1);
    if (push && !load)
      mem_cnt_d = CNT_W'(mem_cnt_q + 1'b1);
    else if (load && !push)
      mem_cnt_d = CNT_W'(mem_cnt_q - 1'b1);
  end

  // holding stage stays full while a word waits to be taken
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      OUT_EMPTY:
        if (load)
          state_d = OUT_HOLD;
      OUT_HOLD:
        if (pop && !load)
          state_d = OUT_EMPTY;
      default:
        state_d = OUT_EMPTY;
    endcase
  end

  // ------------------------------------------------------------
  // storage port
  // ------------------------------------------------------------
  // the beat is captured only on the accepting edge, so upstream
  // must keep it stable until then
  assign st.wr_en = push;
  assign st.wr_addr = wr_ptr_q;
  assign st.wr_word = pack_beat(s_axi_awid, s_axi_awaddr,
                                s_axi_awuser, in_ctrl);
  assign st.inj_single = aw_inject_single_error;
  assign st.inj_double = aw_inject_double_error;
  assign st.rd_addr = rd_ptr_q;

  aw_fifo_store #(
    .DEPTH(DEPTH),
    .W(W),
    .ECC_ENABLE(ECC_ENABLE)
  ) u_store (
    .clk(clk),
    .st(st)
  );

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  // everything on the rising edge of the one clock
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= OUT_EMPTY;
      count_q <= '0;
      mem_cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
      mem_cnt_q <= mem_cnt_d;
    end
  end

  // pointers wrap naturally; single read and write order
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      if (load)
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
    end
  end

  // held word changes only on a refill, so it stays put while
  // downstream stalls
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_word_q <= '0;
      out_single_q <= `AW_FLAG_RST;
      out_double_q <= `AW_FLAG_RST;
    end
    else if (load)
    begin
      out_word_q <= st.rd_word;
      out_single_q <= st.rd_single;
      out_double_q <= st.rd_double;
    end
    else if (pop)
    begin
      out_single_q <= `AW_FLAG_RST;
      out_double_q <= `AW_FLAG_RST;
    end
  end

  // ------------------------------------------------------------
  // master side fields
  // ------------------------------------------------------------
  assign out_ctrl = out_word_q[`AW_CTRL_W-1:0];
  assign m_axi_awuser = out_word_q[`AW_CTRL_W +: USER_W];
  assign m_axi_awaddr = out_word_q[`AW_CTRL_W+USER_W +: ADDR_W];
  assign m_axi_awid = out_word_q[W-1 -: ID_W];
  assign m_axi_awlen = out_ctrl.len;
  assign m_axi_awsize = out_ctrl.size;
  assign m_axi_awburst = out_ctrl.burst;
  assign m_axi_awlock = out_ctrl.lock;
  assign m_axi_awcache = out_ctrl.cache;
  assign m_axi_awprot = out_ctrl.prot;
  assign m_axi_awqos = out_ctrl.qos;
  assign m_axi_awregion = out_ctrl.region;
  assign aw_single_error_flag = out_single_q;
  assign aw_double_error_flag = out_double_q;

  // ------------------------------------------------------------
  // sideband flags
  // ------------------------------------------------------------
  // refused requests flag one cycle later; nothing else moves
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_overflow_flag <= `AW_FLAG_RST;
      aw_underflow_flag <= `AW_FLAG_RST;
    end
    else
    begin
      aw_overflow_flag <= s_axi_awvalid && !s_axi_awready;
      // a ready with nothing held is a read refused as empty
      aw_underflow_flag <= m_axi_awready && !m_axi_awvalid;
    end
  end

  // flags follow the next count so they line up with count_q;
  // thresholds are read live, which is safe as they only move
  // while reset is held
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_threshold_full_flag <= `AW_TFULL_RST;
      aw_threshold_empty_flag <= `AW_TEMPTY_RST;
    end
    else
    begin
      aw_threshold_full_flag <=
        (count_d >= {1'b0, aw_full_threshold});
      aw_threshold_empty_flag <=
        (count_d <= {1'b0, aw_empty_threshold});
    end
  end

  // ------------------------------------------------------------
  // counts
  // ------------------------------------------------------------
  // one clock, so all three views are the exact registered count:
  // a transfer shows at the edge after it is taken
  assign aw_write_side_count = count_q;
  assign aw_read_side_count = count_q;
  assign aw_stored_count = count_q;

endmodule

`default_nettype wire

// file: testbench/aw_fifo_top_properties.sv
// Purpose: port-level properties of the address queue
// Assumes: one clock domain, active-low asynchronous reset
// Notes:   bound into every aw_fifo_top instance
`timescale 1ns/1ps
`default_nettype none

module aw_fifo_top_properties #(
  parameter int DEPTH = 16,
  parameter int ID_W = 4,
  parameter int ADDR_W = 32,
  localparam int AW = $clog2(DEPTH),
  localparam int CNT_W = AW + 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic m_axi_awvalid,
  input wire logic m_axi_awready,
  input wire logic [ID_W-1:0] m_axi_awid,
  input wire logic [ADDR_W-1:0] m_axi_awaddr,
  input wire logic [AW-1:0] aw_full_threshold,
  input wire logic [AW-1:0] aw_empty_threshold,
  input wire logic aw_single_error_flag,
  input wire logic aw_double_error_flag,
  input wire logic aw_overflow_flag,
  input wire logic aw_underflow_flag,
  input wire logic [CNT_W-1:0] aw_write_side_count,
  input wire logic [CNT_W-1:0] aw_read_side_count,
  input wire logic [CNT_W-1:0] aw_stored_count,
  input wire logic aw_threshold_full_flag,
  input wire logic aw_threshold_empty_flag
);
  // --------------------------------------------------------------
  // handshake, occupancy and flag relations
  // --------------------------------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ready_room_a: assert property (
    s_axi_awready == (aw_stored_count < DEPTH))
    else $error("awready disagrees with free room");
  overflow_next_a: assert property (
    1 |=> aw_overflow_flag == $past(s_axi_awvalid && !s_axi_awready))
    else $error("overflow flag wrong");
  underflow_exact_a: assert property (
    1 |=> aw_underflow_flag == $past(m_axi_awready && !m_axi_awvalid))
    else $error("underflow flag wrong");
  hold_stable_a: assert property (
    m_axi_awvalid && !m_axi_awready |=> m_axi_awvalid &&
    $stable(m_axi_awaddr) && $stable(m_axi_awid))
    else $error("presented entry moved before taken");
  fill_latency_a: assert property (
    s_axi_awvalid && s_axi_awready && aw_stored_count == 0 |->
    ##2 m_axi_awvalid)
    else $error("entry not presented after fill");
  count_step_a: assert property (
    1 |=> aw_stored_count == $past(aw_stored_count) +
    $past(s_axi_awvalid && s_axi_awready) -
    $past(m_axi_awvalid && m_axi_awready))
    else $error("count does not track transfers");
  counts_equal_a: assert property (
    aw_write_side_count == aw_stored_count &&
    aw_read_side_count == aw_stored_count)
    else $error("counts disagree");
  thr_full_a: assert property (
    $past(reset_n) |->
    aw_threshold_full_flag == (aw_stored_count >= aw_full_threshold))
    else $error("threshold full flag wrong");
  thr_empty_a: assert property (
    $past(reset_n) |->
    aw_threshold_empty_flag == (aw_stored_count <= aw_empty_threshold))
    else $error("threshold empty flag wrong");
  err_idle_a: assert property (
    !m_axi_awvalid |-> !aw_single_error_flag && !aw_double_error_flag)
    else $error("error flag without a presented word");
endmodule

bind aw_fifo_top aw_fifo_top_properties #(.DEPTH(DEPTH), .ID_W(ID_W),
  .ADDR_W(ADDR_W)) u_props (.clk, .reset_n, .s_axi_awvalid,
  .s_axi_awready, .m_axi_awvalid, .m_axi_awready, .m_axi_awid,
  .m_axi_awaddr, .aw_full_threshold, .aw_empty_threshold,
  .aw_single_error_flag, .aw_double_error_flag, .aw_overflow_flag,
  .aw_underflow_flag, .aw_write_side_count, .aw_read_side_count,
  .aw_stored_count, .aw_threshold_full_flag, .aw_threshold_empty_flag);

`default_nettype wire

// file: testbench/aw_sink_model.sv
// Purpose: downstream address sink on the master port
// Assumes: mode 0 ready, 1 random, 2 stalled, 3 ready with valid
// Notes:   ready changes only after clock edges or with valid
`timescale 1ns/1ps
`default_nettype none

module aw_sink_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  input wire logic awvalid,
  output logic awready
);
  logic [7:0] lfsr_q;

  // stall pattern; random so the holding stage sees uneven drains
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      lfsr_q <= 8'h5a;
    else
      lfsr_q <= {lfsr_q[6:0], ^(lfsr_q & 8'hb8)};

  // a beat is taken only where awvalid meets awready
  always_comb
    case (mode)
      2'h0: awready = 1'b1;
      2'h1: awready = lfsr_q[0];
      2'h2: awready = 1'b0;
      default: awready = awvalid;
    endcase
endmodule

`default_nettype wire

// file: testbench/aw_fifo_top_test.sv
// Purpose: self-checking bench of the write address queue
// Assumes: DEPTH 16, sink model on the master port
// Notes:   seeded xorshift stimulus, in-order scoreboard
`timescale 1ns/1ps
`default_nettype none

module aw_fifo_top_test;
  localparam int DEPTH = 16;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic s_axi_awvalid = 1'b0;
  logic [69:0] s_beat = 70'h0;
  logic [1:0] inj = 2'h0;
  logic [1:0] mode = 2'h0;
  logic [3:0] aw_full_threshold = 4'h0;
  logic [3:0] aw_empty_threshold = 4'h0;
  logic live = 1'b0;
  logic [31:0] seed = 32'h00014704;
  logic [31:0] th;
  logic [4:0] cnt;
  logic [69:0] e;
  logic [1:0] f;
  logic [69:0] exp_q[$];
  logic [1:0] err_q[$];
  int errors = 0;
  int compares = 0;
  wire s_axi_awready, m_axi_awvalid, m_axi_awready;
  wire [69:0] m_beat;
  wire aw_single_error_flag, aw_double_error_flag;
  wire aw_overflow_flag, aw_underflow_flag;
  wire aw_threshold_full_flag, aw_threshold_empty_flag;
  wire [4:0] aw_write_side_count, aw_read_side_count, aw_stored_count;

  always #2 clk = ~clk;

  aw_fifo_top #(.DEPTH(DEPTH)) u_dut (
    .clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awid(s_beat[69:66]), .s_axi_awaddr(s_beat[65:34]),
    .s_axi_awuser(s_beat[33]), .s_axi_awlen(s_beat[32:25]),
    .s_axi_awsize(s_beat[24:22]), .s_axi_awburst(s_beat[21:20]),
    .s_axi_awlock(s_beat[19:17]), .s_axi_awcache(s_beat[16:12]),
    .s_axi_awprot(s_beat[11:8]), .s_axi_awqos(s_beat[7:4]),
    .s_axi_awregion(s_beat[3:0]),
    .m_axi_awid(m_beat[69:66]), .m_axi_awaddr(m_beat[65:34]),
    .m_axi_awuser(m_beat[33]), .m_axi_awlen(m_beat[32:25]),
    .m_axi_awsize(m_beat[24:22]), .m_axi_awburst(m_beat[21:20]),
    .m_axi_awlock(m_beat[19:17]), .m_axi_awcache(m_beat[16:12]),
    .m_axi_awprot(m_beat[11:8]), .m_axi_awqos(m_beat[7:4]),
    .m_axi_awregion(m_beat[3:0]), .m_axi_awvalid, .m_axi_awready,
    .aw_full_threshold, .aw_empty_threshold,
    .aw_inject_single_error(inj[0]), .aw_inject_double_error(inj[1]),
    .aw_single_error_flag, .aw_double_error_flag, .aw_overflow_flag,
    .aw_underflow_flag, .aw_write_side_count, .aw_read_side_count,
    .aw_stored_count, .aw_threshold_full_flag, .aw_threshold_empty_flag);

  aw_sink_model u_sink (.clk, .reset_n, .mode, .awvalid(m_axi_awvalid),
    .awready(m_axi_awready));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic fail(input string msg);
    errors++;
    $display("ERROR %0t %s", $time, msg);
  endtask

  task automatic end_of_test();
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // thresholds move only inside reset, one edge after it bites
  task automatic do_reset(input logic [3:0] fth, input logic [3:0] eth);
    @(negedge clk);
    reset_n = 1'b0;
    s_axi_awvalid = 1'b0;
    exp_q.delete();
    err_q.delete();
    @(negedge clk);
    aw_full_threshold = fth;
    aw_empty_threshold = eth;
    repeat (7) @(negedge clk);
    reset_n = 1'b1;
  endtask

  // first four beats are corners: zeros, ones, each inject code
  task automatic send(input int k);
    logic [95:0] t;
    t = {rnd(), rnd(), rnd()};
    @(negedge clk);
    if (t[95] && k >= 4)
    begin
      s_axi_awvalid = 1'b0;
      @(negedge clk);
    end
    s_beat = (k == 0) ? 70'h0 : (k < 4) ? ~70'h0 : t[69:0];
    inj = (k < 4) ? k[1:0] : t[71:70] & t[73:72];
    s_axi_awvalid = 1'b1;
    // ready moves only on rising edges, so the falling edge shows it
    while (!s_axi_awready)
      @(negedge clk);
    @(posedge clk);
  endtask

  // --------------------------------------------------------------
  // scoreboard and monitors
  // --------------------------------------------------------------
  // pop before push so a fresh beat can never mask a stale one
  always @(posedge clk)
  begin
    live <= reset_n;
    if (reset_n && m_axi_awvalid && m_axi_awready)
    begin
      compares++;
      if (exp_q.size() == 0)
        fail("beat presented from nowhere");
      else
      begin
        e = exp_q.pop_front();
        f = err_q.pop_front();
        compares += 2;
        if (!f[1] && m_beat !== e)
          fail("beat fields or order wrong");
        if ({aw_double_error_flag, aw_single_error_flag} !==
          {f[1], f[0] & ~f[1]})
          fail("error flags wrong");
      end
    end
    if (reset_n && s_axi_awvalid && s_axi_awready)
    begin
      exp_q.push_back(s_beat);
      err_q.push_back(inj);
    end
  end

  // occupancy and threshold flags, checked where settled
  always @(negedge clk)
    if (live && reset_n)
    begin
      cnt = 5'(exp_q.size());
      compares += 3;
      if (aw_stored_count !== cnt || aw_write_side_count !== cnt ||
          aw_read_side_count !== cnt)
        fail("stored count wrong");
      if (aw_threshold_full_flag !== (cnt >= aw_full_threshold))
        fail("threshold full flag wrong");
      if (aw_threshold_empty_flag !== (cnt <= aw_empty_threshold))
        fail("threshold empty flag wrong");
    end

  // watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail("watchdog expired");
    end_of_test();
  end

  // rounds: prompt sink, stalled fill, random sink, valid-led sink
  initial
  begin
    for (int r = 0; r < 4; r++)
    begin
      th = rnd();
      do_reset(r == 0 ? 4'h0 : th[3:0], r == 0 ? 4'hf : th[7:4]);
      @(negedge clk);
      compares++;
      if (m_axi_awvalid !== 1'b0 || aw_stored_count !== 5'h00)
        fail("reset left entries");
      mode = {r[0], r[1]};
      for (int k = 0; k < (r == 1 ? DEPTH : 24); k++)
        send(k);
      if (r == 1)
      begin
        @(negedge clk);
        compares++;
        if (s_axi_awready !== 1'b0 || aw_stored_count !== 5'h10)
          fail("full queue still ready");
        fork
          send(DEPTH);
          begin
            repeat (4) @(negedge clk);
            compares++;
            if (aw_overflow_flag !== 1'b1)
              fail("refused beat not flagged");
            mode = 2'h1;
          end
        join
      end
      @(negedge clk);
      s_axi_awvalid = 1'b0;
      if (r != 1)
      begin
        mode = 2'h0;
        while (exp_q.size() != 0)
          @(negedge clk);
        repeat (2) @(negedge clk);
        compares++;
        if (aw_underflow_flag !== 1'b1 || m_axi_awvalid !== 1'b0)
          fail("idle sink not flagged");
      end
    end
    end_of_test();
  end
endmodule

`default_nettype wire
